// ===== src/wscs_ctrl.sv
module wscs_ctrl
  import wscs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire wscs_pkg::wscs_bus_t bus,
  input wire wscs_pkg::wscs_reg_req_t regReq,
  input wire logic haltStateN,
  input wire logic intN,
  input wire logic nmiN,
  output logic [7:0] regRdData_q,
  output logic low_region_select_n_q,
  output logic high_region_select_n_q,
  output logic cpuWaitN_q,
  output wscs_pkg::wscs_clk_ctrl_t clkCtrl_q
);
  import wscs_pkg::*;

  typedef enum logic [1:0] {WSCS_CLK_RUN, WSCS_CLK_HALTED} wscs_clk_state_t;
  logic rstN;
  logic [7:0] waitCtrl_q;
  logic [7:0] memRange_q;
  logic [7:0] selBound_q;
  logic [7:0] misc_q;
  logic programmed_q;
  logic [4:0] fetchCount_q;
  logic prevMreqN_q;
  logic prevIoreqN_q;
  logic prevFetchN_q;
  logic prevHaltN_q;
  logic pendFetch_q;
  logic afterPrefix_q;
  logic retiFetch_q;
  logic daisyPhase_q;
  logic [3:0] waitCnt_q;
  logic [3:0] waitCnt_d;
  wscs_clk_state_t clkState_q;

  logic memInRange;
  logic lowInRange;
  logic highInRange;
  logic fetchFall;
  logic fetchRise;
  logic mreqFall;
  logic ioreqFall;
  logic fetchStart;
  logic intaStart;
  logic memStart;
  logic ioStart;
  logic vectorStart;
  logic haltEntry;
  logic wakeUp;
  logic [3:0] memWaits;
  logic [3:0] fetchWaits;
  logic [3:0] ioWaits;
  logic [3:0] daisyWaits;
  logic [3:0] retiExtra;
  logic retiLong;
  logic [1:0] haltMode;

  wscs_reset_sync resetSync (
    .clk(clk),
    .reset_n(reset_n),
    .rstN(rstN)
  );

  wscs_nibble_range memRangeCmp (
    .value(bus.addrHigh),
    .lower(memRange_q[3:0]),
    .upper(memRange_q[7:4]),
    .inRange(memInRange)
  );
  wscs_nibble_range lowSelCmp (
    .value(bus.addrHigh),
    .lower(4'h0),
    .upper(selBound_q[3:0]),
    .inRange(lowInRange)
  );
  wscs_nibble_range highSelCmp (
    .value(bus.addrHigh),
    .lower(selBound_q[3:0] + 4'h1),
    .upper(selBound_q[7:4]),
    .inRange(highInRange)
  );

  assign fetchFall = prevFetchN_q && !bus.fetchN;
  assign fetchRise = !prevFetchN_q && bus.fetchN;
  assign mreqFall = prevMreqN_q && !bus.mreqN;
  assign ioreqFall = prevIoreqN_q && !bus.ioreqN;
  // A fetch shows its memory request one sample after the strobe; an acknowledge never does
  assign fetchStart = pendFetch_q && !bus.mreqN;
  assign intaStart = pendFetch_q && bus.mreqN && !bus.fetchN;
  assign memStart = mreqFall && bus.fetchN && bus.rfshN;
  assign ioStart = ioreqFall && bus.fetchN;
  assign vectorStart = ioreqFall && !bus.fetchN;
  assign haltEntry = prevHaltN_q && !haltStateN;
  assign wakeUp = !intN || !nmiN;
  assign haltMode = misc_q[WSCS_MC_HALT_LSB +: 2];

  // Boundary wraps at F, so the high select is gated off there by an explicit check, as intended
  assign memWaits = memInRange ? {2'b00, waitCtrl_q[WSCS_WC_MEM_LSB +: 2]} : 4'h0;
  assign fetchWaits = memWaits + {3'b000, waitCtrl_q[WSCS_WC_FETCH_BIT]};
  assign ioWaits = bus.onChipIo ? 4'h0 : {1'b0, waitCtrl_q[WSCS_WC_IO_LSB +: 2], 1'b0};
  assign daisyWaits = {1'b0, waitCtrl_q[WSCS_WC_DAISY_LSB +: 2], 1'b0};
  assign retiLong = waitCtrl_q[WSCS_WC_DAISY_LSB + 1];
  assign retiExtra = waitCtrl_q[WSCS_WC_DAISY_LSB] ? 4'h3 : 4'h1;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prevMreqN_q <= 1'b1;
      prevIoreqN_q <= 1'b1;
      prevFetchN_q <= 1'b1;
      prevHaltN_q <= 1'b1;
      pendFetch_q <= 1'b0;
    end else begin
      prevMreqN_q <= bus.mreqN;
      prevIoreqN_q <= bus.ioreqN;
      prevFetchN_q <= bus.fetchN;
      prevHaltN_q <= haltStateN;
      pendFetch_q <= fetchFall;
    end
  end

  // Register writes; a write beats the default expiry in the same cycle
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      waitCtrl_q <= WSCS_RST_WAIT_CTRL;
      memRange_q <= WSCS_RST_MEM_RANGE;
      selBound_q <= WSCS_RST_SEL_BOUND;
      misc_q <= WSCS_RST_MISC;
      programmed_q <= 1'b0;
    end else if (regReq.write) begin
      if (regReq.index == WSCS_IDX_WAIT_CTRL) begin
        waitCtrl_q <= regReq.wdata;
        programmed_q <= 1'b1;
      end else if (regReq.index == WSCS_IDX_MEM_RANGE) begin
        memRange_q <= regReq.wdata;
      end else if (regReq.index == WSCS_IDX_SEL_BOUND) begin
        selBound_q <= regReq.wdata;
      end else if (regReq.index == WSCS_IDX_MISC) begin
        // Reserved top bits are held at zero whatever is written
        misc_q <= regReq.wdata & WSCS_MC_WRITE_MASK;
      end
    end else if (fetchRise && !programmed_q && fetchCount_q == WSCS_DEFAULT_FETCHES - 5'd1) begin
      waitCtrl_q <= 8'h00;
    end
  end

  // Counts trailing fetch edges until the defaults expire
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      fetchCount_q <= 5'd0;
    end else if (fetchRise && fetchCount_q != WSCS_DEFAULT_FETCHES) begin
      fetchCount_q <= fetchCount_q + 5'd1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdData_q <= 8'h00;
    end else if (regReq.index == WSCS_IDX_WAIT_CTRL) begin
      regRdData_q <= waitCtrl_q;
    end else if (regReq.index == WSCS_IDX_MEM_RANGE) begin
      regRdData_q <= memRange_q;
    end else if (regReq.index == WSCS_IDX_SEL_BOUND) begin
      regRdData_q <= selBound_q;
    end else if (regReq.index == WSCS_IDX_MISC) begin
      regRdData_q <= misc_q;
    end else begin
      regRdData_q <= 8'h00;
    end
  end

  // Return-from-interrupt tracking: a prefix fetch arms the next one; the opcode is
  // taken as the fetch starts, since the released bus no longer holds it at the end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      afterPrefix_q <= 1'b0;
      retiFetch_q <= 1'b0;
    end else begin
      if (fetchStart) begin
        afterPrefix_q <= !(afterPrefix_q && retiLong) && bus.data == WSCS_OP_PREFIX;
        retiFetch_q <= afterPrefix_q && retiLong;
      end else if (fetchRise || (retiFetch_q && bus.data == WSCS_OP_RETURN)) begin
        retiFetch_q <= 1'b0;
      end
    end
  end

  always_comb begin
    waitCnt_d = (waitCnt_q != 4'h0) ? waitCnt_q - 4'h1 : 4'h0;
    if (fetchStart) begin
      waitCnt_d = fetchWaits + ((afterPrefix_q && retiLong) ? WSCS_ONE_WAIT : 4'h0);
    end else if (intaStart) begin
      waitCnt_d = daisyWaits;
    end else if (memStart) begin
      waitCnt_d = memWaits;
    end else if (ioStart) begin
      waitCnt_d = ioWaits;
    end else if (vectorStart) begin
      waitCnt_d = {3'b000, waitCtrl_q[WSCS_WC_VECTOR_BIT]};
    end else if (retiFetch_q && bus.data == WSCS_OP_RETURN) begin
      // Opcode is seen a cycle late; the wait already loaded counts toward the total
      waitCnt_d = waitCnt_q - 4'h1 + retiExtra;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      waitCnt_q <= 4'h0;
      daisyPhase_q <= 1'b0;
    end else begin
      waitCnt_q <= waitCnt_d;
      daisyPhase_q <= intaStart || (daisyPhase_q && bus.ioreqN && !bus.fetchN);
    end
  end

  // External wait only counts once internal waits are spent, except in daisy settle
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cpuWaitN_q <= 1'b1;
    end else begin
      cpuWaitN_q <= !((waitCnt_d != 4'h0) ||
                      (!bus.extWaitN && (waitCnt_d == 4'h0 || daisyPhase_q)));
    end
  end

  // Selects only in real memory cycles, never refresh
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      low_region_select_n_q <= 1'b1;
      high_region_select_n_q <= 1'b1;
    end else begin
      low_region_select_n_q <= !(!bus.mreqN && bus.rfshN && misc_q[WSCS_MC_LOW_EN_BIT] &&
                                 lowInRange);
      high_region_select_n_q <= !(!bus.mreqN && bus.rfshN && misc_q[WSCS_MC_HIGH_EN_BIT] &&
                                  highInRange && selBound_q[3:0] != 4'hf);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      clkState_q <= WSCS_CLK_RUN;
    end else begin
      case (clkState_q)
        WSCS_CLK_RUN: begin
          if (haltEntry && haltMode != WSCS_HALT_RUN) begin
            clkState_q <= WSCS_CLK_HALTED;
          end
        end
        WSCS_CLK_HALTED: begin
          if (wakeUp) begin
            clkState_q <= WSCS_CLK_RUN;
          end
        end
        default: clkState_q <= WSCS_CLK_RUN;
      endcase
    end
  end

  // Clock gating; the mode is latched with the halt, so a later write has no effect
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      clkCtrl_q <= '{oscRun: 1'b1, clkOutRun: 1'b1, coreRun: 1'b1, timerRun: 1'b1,
                     divBypass: 1'b0};
    end else begin
      clkCtrl_q.divBypass <= misc_q[WSCS_MC_DIV_BYPASS_BIT];
      if (clkState_q == WSCS_CLK_HALTED && wakeUp) begin
        clkCtrl_q.oscRun <= 1'b1;
        clkCtrl_q.clkOutRun <= 1'b1;
        clkCtrl_q.coreRun <= 1'b1;
        clkCtrl_q.timerRun <= 1'b1;
      end else if (clkState_q == WSCS_CLK_RUN && haltEntry) begin
        case (haltMode)
          WSCS_HALT_IDLE_OSC: begin
            clkCtrl_q.clkOutRun <= 1'b0;
            clkCtrl_q.coreRun <= 1'b0;
            clkCtrl_q.timerRun <= 1'b0;
          end
          WSCS_HALT_IDLE_TIMER: begin
            clkCtrl_q.coreRun <= 1'b0;
          end
          WSCS_HALT_STOP: begin
            clkCtrl_q.oscRun <= 1'b0;
            clkCtrl_q.clkOutRun <= 1'b0;
            clkCtrl_q.coreRun <= 1'b0;
            clkCtrl_q.timerRun <= 1'b0;
          end
          default: begin
            clkCtrl_q.coreRun <= 1'b1;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);
  sequence haltEnterSeq;
    clkState_q == WSCS_CLK_RUN && haltEntry;
  endsequence
  sequence wakeSeq;
    clkState_q == WSCS_CLK_HALTED && wakeUp;
  endsequence
  low_select_decode_a: assert property (
    (!bus.mreqN && bus.rfshN && misc_q[WSCS_MC_LOW_EN_BIT] && bus.addrHigh <= selBound_q[3:0])
    |=> !low_region_select_n_q)
    else $error("low select missing");
  high_select_gate_a: assert property (
    !misc_q[WSCS_MC_HIGH_EN_BIT] |=> high_region_select_n_q)
    else $error("high select active while disabled");
  select_memory_only_a: assert property (
    (bus.mreqN || !bus.rfshN) |=> low_region_select_n_q && high_region_select_n_q)
    else $error("select outside memory cycle");
  memory_wait_load_a: assert property (
    (memStart && !memInRange) |=> waitCnt_q == 4'h0)
    else $error("memory wait outside range");
  fetch_extend_a: assert property (
    (fetchStart && !afterPrefix_q && waitCtrl_q[WSCS_WC_FETCH_BIT])
    |=> waitCnt_q == memWaits + 4'h1 && !cpuWaitN_q)
    else $error("fetch extension wrong");
  io_wait_skip_a: assert property (
    (ioStart && bus.onChipIo) |=> waitCnt_q == 4'h0)
    else $error("on-chip I/O got waits");
  vector_wait_a: assert property (
    (vectorStart && waitCtrl_q[WSCS_WC_VECTOR_BIT]) |=> waitCnt_q == 4'h1 ##1 waitCnt_q == 4'h0)
    else $error("vector wait wrong");
  daisy_wait_a: assert property (
    (intaStart && waitCtrl_q[WSCS_WC_DAISY_LSB +: 2] == 2'b11) |=> waitCnt_q == 4'h6)
    else $error("daisy wait count wrong");
  default_hold_a: assert property (
    (!programmed_q && fetchCount_q < WSCS_DEFAULT_FETCHES - 5'd1)
    |-> waitCtrl_q == WSCS_RST_WAIT_CTRL)
    else $error("wait defaults lost early");
  idle_osc_stop_a: assert property (
    haltEnterSeq and (haltMode == WSCS_HALT_IDLE_OSC) |=> !clkCtrl_q.clkOutRun && clkCtrl_q.oscRun)
    else $error("idle mode clocks wrong");
  wake_restart_a: assert property (
    wakeSeq |=> clkCtrl_q.coreRun && clkCtrl_q.oscRun)
    else $error("clock not restarted");
  wait_merge_a: assert property (
    (!bus.extWaitN && waitCnt_d == 4'h0) |=> !cpuWaitN_q)
    else $error("external wait dropped");
endmodule

// ===== src/wscs_pkg.sv
package wscs_pkg;
  // Control register indices
  localparam logic [7:0] WSCS_IDX_WAIT_CTRL = 8'h00;
  localparam logic [7:0] WSCS_IDX_MEM_RANGE = 8'h01;
  localparam logic [7:0] WSCS_IDX_SEL_BOUND = 8'h02;
  localparam logic [7:0] WSCS_IDX_MISC = 8'h03;

  // Reset values
  localparam logic [7:0] WSCS_RST_WAIT_CTRL = 8'hff;
  localparam logic [7:0] WSCS_RST_MEM_RANGE = 8'hf0;
  localparam logic [7:0] WSCS_RST_SEL_BOUND = 8'h0f;
  localparam logic [7:0] WSCS_RST_MISC = 8'h0d;

  // Wait control fields
  localparam int WSCS_WC_DAISY_LSB = 6;
  localparam int WSCS_WC_VECTOR_BIT = 5;
  localparam int WSCS_WC_FETCH_BIT = 4;
  localparam int WSCS_WC_MEM_LSB = 2;
  localparam int WSCS_WC_IO_LSB = 0;

  // Misc option fields
  localparam int WSCS_MC_LOW_EN_BIT = 0;
  localparam int WSCS_MC_HIGH_EN_BIT = 1;
  localparam int WSCS_MC_HALT_LSB = 2;
  localparam int WSCS_MC_DIV_BYPASS_BIT = 4;
  localparam logic [7:0] WSCS_MC_WRITE_MASK = 8'h1f;

  // Halt clock modes
  localparam logic [1:0] WSCS_HALT_IDLE_OSC = 2'b00;
  localparam logic [1:0] WSCS_HALT_IDLE_TIMER = 2'b01;
  localparam logic [1:0] WSCS_HALT_STOP = 2'b10;
  localparam logic [1:0] WSCS_HALT_RUN = 2'b11;

  // Fetch sequence constants
  localparam logic [4:0] WSCS_DEFAULT_FETCHES = 5'd16;
  localparam logic [7:0] WSCS_OP_PREFIX = 8'hed;
  localparam logic [7:0] WSCS_OP_RETURN = 8'h4d;
  localparam logic [3:0] WSCS_ONE_WAIT = 4'h1;

  typedef struct packed {
    logic [3:0] addrHigh;
    logic mreqN;
    logic ioreqN;
    logic fetchN;
    logic rfshN;
    logic onChipIo;
    logic extWaitN;
    logic [7:0] data;
  } wscs_bus_t;

  typedef struct packed {
    logic write;
    logic [7:0] index;
    logic [7:0] wdata;
  } wscs_reg_req_t;

  typedef struct packed {
    logic oscRun;
    logic clkOutRun;
    logic coreRun;
    logic timerRun;
    logic divBypass;
  } wscs_clk_ctrl_t;
endpackage

// ===== src/wscs_reset_sync.sv
module wscs_reset_sync (
  input wire logic clk,
  input wire logic reset_n,
  output logic rstN
);
  logic stage1_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= 1'b0;
      rstN <= 1'b0;
    end else begin
      stage1_q <= 1'b1;
      rstN <= stage1_q;
    end
  end
endmodule

// ===== src/wscs_nibble_range.sv
module wscs_nibble_range (
  input wire logic [3:0] value,
  input wire logic [3:0] lower,
  input wire logic [3:0] upper,
  output logic inRange
);
  assign inRange = (value >= lower) && (value <= upper);
endmodule

// ===== testbench/wscs_cpu_model.sv
module wscs_cpu_model (
  input wire logic clk,
  input wire logic cpuWaitN_q,
  output wscs_pkg::wscs_bus_t bus,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;
  import wscs_pkg::*;

  initial begin
    bus = '1;
    bus.onChipIo = 1'b0;
    bus.data = 8'h00;
    hung = 1'b0;
  end

  // Waits are read just after a falling edge, where the registered wait has settled
  task automatic waitDone(input int ext, input int minK);
    int k;
    k = 0;
    repeat (40) begin
      @(negedge clk);
      k++;
      if (k >= minK && k > ext && cpuWaitN_q === 1'b1) return;
      if (k >= ext) bus.extWaitN = 1'b1;
    end
    hung = 1'b1;
  endtask

  // Released data bus shows the inverse so a stale byte is never mistaken for an opcode
  task automatic idle();
    bus.mreqN = 1'b1;
    bus.ioreqN = 1'b1;
    bus.fetchN = 1'b1;
    bus.rfshN = 1'b1;
    bus.data = ~bus.data;
  endtask

  task automatic memCycle(input logic [3:0] a, input int ext, input logic rf);
    @(negedge clk);
    bus.addrHigh = a;
    bus.mreqN = 1'b0;
    bus.rfshN = ~rf;
    bus.extWaitN = (ext == 0);
    waitDone(ext, 2);
    idle();
  endtask

  // Fetch strobe leads the memory request by one cycle
  task automatic fetchCycle(input logic [3:0] a, input logic [7:0] op);
    @(negedge clk);
    bus.addrHigh = a;
    bus.fetchN = 1'b0;
    @(negedge clk);
    bus.mreqN = 1'b0;
    bus.data = op;
    waitDone(0, 2);
    idle();
  endtask

  task automatic ioCycle(input logic onChip);
    @(negedge clk);
    bus.ioreqN = 1'b0;
    bus.onChipIo = onChip;
    waitDone(0, 2);
    idle();
  endtask

  // Acknowledge is only known one cycle after the strobe, so the first wait is later
  task automatic intAck();
    @(negedge clk);
    bus.fetchN = 1'b0;
    waitDone(0, 3);
    bus.ioreqN = 1'b0;
    waitDone(0, 2);
    idle();
  endtask
endmodule

// ===== testbench/wscs_ctrl_tb_top.sv
module wscs_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wscs_pkg::*;

  typedef struct packed {
    logic [3:0] w;
    logic lo;
    logic hi;
  } wscs_res_t;

  logic clk, reset_n, haltStateN, intN, nmiN, lowSelN, highSelN, cpuWaitN_q, hung;
  logic seenL, seenH, act, wasAct;
  logic [7:0] regRdData_q, sb, mr, wc;
  logic [1:0] en;
  logic [3:0] runs [4] = '{4'b1000, 4'b1101, 4'b0000, 4'b1111};
  int mismatches, nChecks, seenW;
  wscs_reg_req_t regReq;
  wscs_bus_t bus;
  wscs_clk_ctrl_t clkCtrl_q;
  wscs_res_t expQ [$];

  wscs_ctrl dut (.clk(clk), .reset_n(reset_n), .bus(bus), .regReq(regReq),
    .haltStateN(haltStateN), .intN(intN), .nmiN(nmiN), .regRdData_q(regRdData_q),
    .low_region_select_n_q(lowSelN), .high_region_select_n_q(highSelN),
    .cpuWaitN_q(cpuWaitN_q), .clkCtrl_q(clkCtrl_q));
  wscs_cpu_model cpu (.clk(clk), .cpuWaitN_q(cpuWaitN_q), .bus(bus), .hung(hung));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic giveVerdict();
    if (expQ.size() != 0) begin
      mismatches++;
      $display("BAD cycle exp %0d more got none", expQ.size());
    end
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmpVal(input string what, input logic [7:0] e, input logic [7:0] g);
    nChecks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic cmpCycle(input wscs_res_t e, input wscs_res_t g);
    nChecks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD cycle waits and selects exp %h got %h", e, g);
    end
  endtask

  task automatic note(input logic [3:0] w, input logic lo, input logic hi);
    expQ.push_back('{w, lo, hi});
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk);
    regReq = '{1'b1, i, d};
    @(negedge clk);
    regReq.write = 1'b0;
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk);
    regReq.index = i;
    repeat (2) @(negedge clk);
    cmpVal("register", e, regRdData_q);
  endtask

  // Totals waits and any select activity over each bus cycle, judged when it ends
  always @(posedge clk) begin
    act = !bus.mreqN || !bus.ioreqN || !bus.fetchN;
    if (act) begin
      if (cpuWaitN_q === 1'b0) seenW++;
      seenL &= lowSelN;
      seenH &= highSelN;
    end else if (wasAct) begin
      if (expQ.size() == 0) begin
        mismatches++;
        $display("BAD cycle exp none got one");
      end else cmpCycle(expQ.pop_front(), wscs_res_t'{seenW[3:0], seenL, seenH});
      seenW = 0;
      seenL = 1'b1;
      seenH = 1'b1;
    end
    wasAct = act;
  end

  always @(posedge hung) begin
    mismatches++;
    giveVerdict();
  end

  initial begin
    reset_n = 1'b0;
    haltStateN = 1'b1;
    intN = 1'b1;
    nmiN = 1'b1;
    regReq = '0;
    {seenW, mismatches, nChecks} = '0;
    {seenL, seenH, wasAct} = 3'b110;
    void'($urandom(32'h9f0e728c));
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(WSCS_IDX_WAIT_CTRL, 8'hff);
    rd(WSCS_IDX_MEM_RANGE, 8'hf0);
    rd(WSCS_IDX_SEL_BOUND, 8'h0f);
    rd(WSCS_IDX_MISC, 8'h0d);
    rd(8'h04, 8'h00);
    cmpVal("clocks", 8'h1e, {3'b0, clkCtrl_q});
    $display("done reset values");
    note(4'd3, 1'b0, 1'b1); cpu.memCycle(4'h7, 0, 1'b0);
    note(4'd6, 1'b1, 1'b1); cpu.ioCycle(1'b0);
    note(4'd0, 1'b1, 1'b1); cpu.ioCycle(1'b1);
    repeat (16) begin
      note(4'd4, 1'b0, 1'b1); cpu.fetchCycle(4'h2, 8'h00);
    end
    rd(WSCS_IDX_WAIT_CTRL, 8'h00);
    note(4'd0, 1'b0, 1'b1); cpu.memCycle(4'hf, 0, 1'b0);
    note(4'd0, 1'b1, 1'b1); cpu.memCycle(4'h0, 0, 1'b1);
    wr(WSCS_IDX_MISC, 8'h1f);
    rd(WSCS_IDX_MISC, 8'h1f);
    cmpVal("clocks", 8'h1f, {3'b0, clkCtrl_q});
    $display("done defaults");
    for (int n = 0; n < 6; n++) begin
      sb = $urandom;
      mr = $urandom;
      en = $urandom;
      wc = {4'h0, 2'($urandom), 2'b00};
      wr(WSCS_IDX_SEL_BOUND, sb);
      wr(WSCS_IDX_MEM_RANGE, mr);
      wr(WSCS_IDX_WAIT_CTRL, wc);
      wr(WSCS_IDX_MISC, {4'h0, 2'b11, en});
      rd(WSCS_IDX_SEL_BOUND, sb);
      for (int a = 0; a < 16; a++) begin
        note((a >= mr[3:0] && a <= mr[7:4]) ? wc[3:2] : 2'd0, !(en[0] && a <= sb[3:0]),
          !(en[1] && a > sb[3:0] && a <= sb[7:4]));
        cpu.memCycle(4'(a), 0, 1'b0);
      end
    end
    $display("done select and range sweep");
    wr(WSCS_IDX_MISC, 8'h0d);
    wr(WSCS_IDX_SEL_BOUND, 8'h0f);
    wr(WSCS_IDX_MEM_RANGE, 8'hf0);
    wr(WSCS_IDX_WAIT_CTRL, 8'h14);
    note(4'd2, 1'b0, 1'b1); cpu.fetchCycle(4'h3, 8'h00);
    note(4'd1, 1'b0, 1'b1); cpu.memCycle(4'h3, 0, 1'b0);
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 2; v++) begin
        wr(WSCS_IDX_WAIT_CTRL, {2'(c), 1'(v), 3'b000, 2'(c)});
        note(4'(2 * c), 1'b1, 1'b1); cpu.ioCycle(1'b0);
        note(4'd0, 1'b1, 1'b1); cpu.ioCycle(1'b1);
        note(4'(2 * c + v), 1'b1, 1'b1); cpu.intAck();
        note(4'd0, 1'b0, 1'b1); cpu.fetchCycle(4'h0, WSCS_OP_PREFIX);
        note(4'(c < 2 ? 0 : (v == 1 ? 2 * c - 2 : 1)), 1'b0, 1'b1);
        cpu.fetchCycle(4'h0, v == 1 ? WSCS_OP_RETURN : 8'h12);
      end
    end
    $display("done io and interrupt waits");
    wr(WSCS_IDX_WAIT_CTRL, 8'h00);
    note(4'd3, 1'b0, 1'b1); cpu.memCycle(4'h5, 3, 1'b0);
    $display("done external wait");
    for (int m = 0; m < 4; m++) begin
      wr(WSCS_IDX_MISC, {3'b000, 1'(m), 2'(m), 2'b01});
      haltStateN = 1'b0;
      repeat (2) @(negedge clk);
      cmpVal("halt clocks", {3'b0, runs[m], 1'(m)}, {3'b0, clkCtrl_q});
      if (m % 2 == 1) nmiN = 1'b0;
      else intN = 1'b0;
      repeat (2) @(negedge clk);
      cmpVal("wake clocks", {3'b0, 4'hf, 1'(m)}, {3'b0, clkCtrl_q});
      intN = 1'b1;
      nmiN = 1'b1;
      haltStateN = 1'b1;
      @(negedge clk);
    end
    $display("done halt modes");
    repeat (3) @(negedge clk);
    giveVerdict();
  end
endmodule
